// File: pkg/stop_seq_pkg.sv
// Constants and types shared by the servo alarm and stop sequencer.
// How it works
// - Opening the forced-stop contact enters forced stop, turns the servo off and applies the dynamic brake.
// - Closing the forced-stop contact again leaves the forced-stop state.
// - Any alarm shuts off the power-stage drive at once.
// - An alarm clears on a control-power failure of 40 ms or more, an error reset or a CPU reset.
// - Clear requests are ignored while the alarm cause is still present.
// - The overcurrent alarm (32) removes drive without the dynamic brake.
// - Loss of control power leaves the dynamic brake off so the motor coasts.
// - Overload is reported as code 50 for class one and 51 for class two.
// - Control power returning after a failure of 40 ms or more raises undervoltage (10).
// - A bus voltage at or below 20 V DC also raises undervoltage.
// - A control-power failure that persists clears the alarm and returns to the initial state.
// - With control power on and main power off a warning shows until main power comes on.
// - Servo-on is accepted only about 1 s after main power comes on.
// - Forced stop shows a dedicated forced-stop warning code.
`default_nettype none
package stop_seq_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned PFAIL_MS        = 40;
  localparam int unsigned SON_DELAY_MS    = 1000;
  localparam int unsigned PFAIL_CYC       = CLK_HZ / 1000 * PFAIL_MS;
  localparam int unsigned SON_DELAY_CYC   = CLK_HZ / 1000 * SON_DELAY_MS;
  localparam int unsigned CNT_W           = 24;
  localparam logic [7:0]  CODE_NONE       = 8'h00;
  localparam logic [7:0]  CODE_UNDERVOLT  = 8'h10;
  localparam logic [7:0]  CODE_OVERCUR    = 8'h32;
  localparam logic [7:0]  CODE_OVERLOAD1  = 8'h50;
  localparam logic [7:0]  CODE_OVERLOAD2  = 8'h51;
  localparam logic [7:0]  CODE_WARN_MAIN  = 8'hE9;
  localparam logic [7:0]  CODE_WARN_STOP  = 8'hE6;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_RUN   = 4'b0010,
    ST_STOP  = 4'b0100,
    ST_ALARM = 4'b1000
  } seq_state_t;

  typedef struct packed {
    logic overcurrent;
    logic overload1;
    logic overload2;
    logic bus_low;
  } fault_in_t;

  typedef struct packed {
    logic error_reset;
    logic cpu_reset;
  } clear_req_t;
endpackage
`default_nettype wire

// File: hdl/sync2.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// File: hdl/servo_alarm_stop_sequencer.sv
// Forced stop, alarm and power-up sequencing for a servo amplifier.
`default_nettype none
module servo_alarm_stop_sequencer
  import stop_seq_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       forced_stop_input,
  input  wire logic       main_power_input,
  input  wire logic       control_power_input,
  input  wire logic       servo_on_command,
  input  wire clear_req_t clear_req,
  input  wire fault_in_t  fault_in,
  output logic            base_drive_on,
  output logic            dyn_brake_on,
  output logic            alarm_active,
  output logic [7:0]      alarm_code,
  output logic [7:0]      display_code,
  output logic            forced_stop_active,
  output logic            main_power_warning,
  output logic            son_ready
);
  // ==========================================================
  // Input synchronisation
  // ==========================================================
  // All levels here come from pins or a foreign controller.
  localparam int unsigned NSYNC = 10;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  logic       stop_closed;
  logic       main_on;
  logic       ctrl_on;
  logic       son_cmd;
  logic       err_rst;
  logic       cpu_rst;
  fault_in_t  flt;

  // The forced-stop contact travels inverted, so that the reset value of the
  // synchroniser reads as a closed contact and no false stop follows reset.
  assign raw_in = {~forced_stop_input, main_power_input, control_power_input,
                   servo_on_command, clear_req.error_reset,
                   clear_req.cpu_reset, fault_in};

  sync2 #(.W(NSYNC)) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (clk_en),
    .d       (raw_in),
    .q       (syn)
  );

  assign stop_closed = ~syn[9];
  assign main_on     = syn[8];
  assign ctrl_on     = syn[7];
  assign son_cmd     = syn[6];
  assign err_rst     = syn[5];
  assign cpu_rst     = syn[4];
  assign flt         = fault_in_t'(syn[3:0]);

  // ==========================================================
  // Control power loss timer
  // ==========================================================
  logic [CNT_W-1:0] off_cnt_r;
  logic [CNT_W-1:0] off_cnt_nxt;
  logic             ctrl_on_r;
  logic             ctrl_on_nxt;
  logic             long_fail_r;
  logic             long_fail_nxt;
  logic             uv_return;

  always_comb begin
    off_cnt_nxt   = off_cnt_r;
    long_fail_nxt = long_fail_r;
    ctrl_on_nxt   = ctrl_on;
    uv_return     = 1'b0;
    if (!ctrl_on) begin
      if (off_cnt_r != CNT_W'(PFAIL_CYC))
        off_cnt_nxt = off_cnt_r + CNT_W'(1);
      else
        long_fail_nxt = 1'b1;
    end else begin
      off_cnt_nxt   = '0;
      long_fail_nxt = 1'b0;
      // Return of control power after a long failure.
      uv_return = ctrl_on && !ctrl_on_r && long_fail_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      off_cnt_r   <= '0;
      long_fail_r <= 1'b0;
      ctrl_on_r   <= 1'b0;
    end else if (clk_en) begin
      off_cnt_r   <= off_cnt_nxt;
      long_fail_r <= long_fail_nxt;
      ctrl_on_r   <= ctrl_on_nxt;
    end
  end

  // ==========================================================
  // Main power delay before servo-on
  // ==========================================================
  logic [CNT_W-1:0] on_cnt_r;
  logic [CNT_W-1:0] on_cnt_nxt;
  logic             son_ok;

  always_comb begin
    on_cnt_nxt = on_cnt_r;
    if (!main_on || !ctrl_on)
      on_cnt_nxt = '0;
    else if (on_cnt_r != CNT_W'(SON_DELAY_CYC))
      on_cnt_nxt = on_cnt_r + CNT_W'(1);
  end

  assign son_ok = (on_cnt_r == CNT_W'(SON_DELAY_CYC));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      on_cnt_r <= '0;
    else if (clk_en)
      on_cnt_r <= on_cnt_nxt;
  end

  // ==========================================================
  // Alarm capture and clearing
  // ==========================================================
  logic       cause_now;
  logic [7:0] cause_code;
  logic [7:0] code_r;
  logic [7:0] code_nxt;
  logic       alm_r;
  logic       alm_nxt;
  logic       clear_hit;

  always_comb begin
    cause_now  = 1'b1;
    cause_code = CODE_NONE;
    if (flt.overcurrent)
      cause_code = CODE_OVERCUR;
    else if (flt.overload2)
      cause_code = CODE_OVERLOAD2;
    else if (flt.overload1)
      cause_code = CODE_OVERLOAD1;
    else if (flt.bus_low || uv_return)
      cause_code = CODE_UNDERVOLT;
    else
      cause_now = 1'b0;
  end

  // A reset only counts once the cause has gone away.
  assign clear_hit = (err_rst || cpu_rst) && !cause_now;

  always_comb begin
    alm_nxt  = alm_r;
    code_nxt = code_r;
    if (!ctrl_on) begin
      // Control power gone past the 40 ms failure time: alarm state is dropped for a fresh start.
      if (long_fail_r) begin
        alm_nxt  = 1'b0;
        code_nxt = CODE_NONE;
      end
    end else if (cause_now && !alm_r) begin
      alm_nxt  = 1'b1;
      code_nxt = cause_code;
    end else if (alm_r && clear_hit) begin
      alm_nxt  = 1'b0;
      code_nxt = CODE_NONE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alm_r  <= 1'b0;
      code_r <= CODE_NONE;
    end else if (clk_en) begin
      alm_r  <= alm_nxt;
      code_r <= code_nxt;
    end
  end

  // ==========================================================
  // Sequencer state machine
  // ==========================================================
  seq_state_t st_r;
  seq_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (alm_nxt)
          st_nxt = ST_ALARM;
        else if (!stop_closed)
          st_nxt = ST_STOP;
        else if (son_cmd && son_ok)
          st_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (alm_nxt)
          st_nxt = ST_ALARM;
        else if (!stop_closed)
          st_nxt = ST_STOP;
        else if (!son_cmd || !son_ok)
          st_nxt = ST_IDLE;
      end
      ST_STOP: begin
        if (alm_nxt)
          st_nxt = ST_ALARM;
        else if (stop_closed)
          st_nxt = ST_IDLE;
      end
      ST_ALARM: begin
        if (!alm_nxt)
          st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      st_r <= ST_IDLE;
    else if (clk_en)
      st_r <= st_nxt;
  end

  // ==========================================================
  // Registered outputs
  // ==========================================================
  logic       drive_nxt;
  logic       brake_nxt;
  logic       warn_nxt;
  logic [7:0] disp_nxt;

  always_comb begin
    drive_nxt = (st_nxt == ST_RUN);
    brake_nxt = 1'b0;
    if (ctrl_on) begin
      // No brake on overcurrent or without control power.
      if (st_nxt == ST_STOP)
        brake_nxt = 1'b1;
      else if (st_nxt == ST_ALARM && code_nxt != CODE_OVERCUR)
        brake_nxt = 1'b1;
    end
    warn_nxt = ctrl_on && !main_on;
    if (st_nxt == ST_ALARM)
      disp_nxt = code_nxt;
    else if (st_nxt == ST_STOP)
      disp_nxt = CODE_WARN_STOP;
    else if (warn_nxt)
      disp_nxt = CODE_WARN_MAIN;
    else
      disp_nxt = CODE_NONE;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_drive_on      <= 1'b0;
      dyn_brake_on       <= 1'b0;
      alarm_active       <= 1'b0;
      alarm_code         <= CODE_NONE;
      display_code       <= CODE_NONE;
      forced_stop_active <= 1'b0;
      main_power_warning <= 1'b0;
      son_ready          <= 1'b0;
    end else if (clk_en) begin
      base_drive_on      <= drive_nxt;
      dyn_brake_on       <= brake_nxt;
      alarm_active       <= alm_nxt;
      alarm_code         <= code_nxt;
      display_code       <= disp_nxt;
      forced_stop_active <= (st_nxt == ST_STOP);
      main_power_warning <= warn_nxt;
      son_ready          <= son_ok;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  stop_brake_a: assert property (clk_en && ctrl_on && !stop_closed && !alm_nxt
      && st_r != ST_ALARM
      |=> forced_stop_active && dyn_brake_on && !base_drive_on)
    else $error("forced stop did not brake");
  stop_leave_a: assert property (st_r == ST_STOP && clk_en && stop_closed
      && !alm_nxt |=> !forced_stop_active)
    else $error("forced stop not left");
  alarm_drive_a: assert property (alarm_active |-> !base_drive_on)
    else $error("drive on during alarm");
  clear_cause_a: assert property (alm_r && cause_now && ctrl_on
      |=> alarm_active || !clk_en)
    else $error("alarm cleared with cause present");
  clear_reset_a: assert property (clk_en && alm_r && ctrl_on && clear_hit
      |=> !alarm_active)
    else $error("alarm not cleared by reset");
  ovc_coast_a: assert property (alarm_code == CODE_OVERCUR
      |-> !dyn_brake_on)
    else $error("brake on overcurrent");
  no_ctrl_coast_a: assert property (clk_en && !ctrl_on
      |=> !dyn_brake_on)
    else $error("brake without control power");
  son_delay_a: assert property (base_drive_on |-> son_ready)
    else $error("drive before servo-on delay");
  main_warn_a: assert property (clk_en && ctrl_on && !main_on
      |=> main_power_warning)
    else $error("main power warning missing");
  stop_code_a: assert property (forced_stop_active
      |-> display_code == CODE_WARN_STOP)
    else $error("forced stop code missing");

  run_cov_c: cover property (st_r == ST_RUN);
  stop_cov_c: cover property (st_r == ST_STOP ##1 st_r == ST_IDLE);
  alarm_cov_c: cover property (alarm_active ##1 !alarm_active);
  uv_cov_c: cover property (uv_return);
endmodule
`default_nettype wire

// File: dv/power_relay_model.sv
// External power relay sequence that feeds the amplifier supplies.
`default_nettype none
module power_relay_model #(
  parameter int unsigned MAIN_LAG = 8
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic power_req,
  input  wire logic alarm_active,
  output logic      control_power_input,
  output logic      main_power_input
);
  timeunit 1ns;
  timeprecision 1ns;

  int unsigned lag_r;

  // =========================================================
  // Relay sequence
  // Main power closes only some cycles after control power.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_power_input <= 1'b0;
      main_power_input    <= 1'b0;
      lag_r               <= 0;
    end else begin
      control_power_input <= power_req;
      if (!power_req || alarm_active) begin
        main_power_input <= 1'b0;
        lag_r            <= 0;
      end else if (lag_r == MAIN_LAG) begin
        main_power_input <= 1'b1;
      end else begin
        lag_r <= lag_r + 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/servo_alarm_stop_sequencer_tb_top.sv
// Self-checking bench for the alarm and stop sequencer.
`default_nettype none
module servo_alarm_stop_sequencer_tb_top
  import stop_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       ref_clk;
  logic       rst_n;
  logic       clk_en;
  logic       forced_stop_input;
  logic       main_power_input;
  logic       control_power_input;
  logic       servo_on_command;
  logic       power_req;
  clear_req_t clear_req;
  fault_in_t  fault_in;
  logic       base_drive_on;
  logic       dyn_brake_on;
  logic       alarm_active;
  logic [7:0] alarm_code;
  logic [7:0] display_code;
  logic       forced_stop_active;
  logic       main_power_warning;
  logic       son_ready;
  int         miscompares;
  int         checked;

  servo_alarm_stop_sequencer servo_alarm_stop_sequencer_i (
    .ref_clk             (ref_clk),
    .rst_n               (rst_n),
    .clk_en              (clk_en),
    .forced_stop_input   (forced_stop_input),
    .main_power_input    (main_power_input),
    .control_power_input (control_power_input),
    .servo_on_command    (servo_on_command),
    .clear_req           (clear_req),
    .fault_in            (fault_in),
    .base_drive_on       (base_drive_on),
    .dyn_brake_on        (dyn_brake_on),
    .alarm_active        (alarm_active),
    .alarm_code          (alarm_code),
    .display_code        (display_code),
    .forced_stop_active  (forced_stop_active),
    .main_power_warning  (main_power_warning),
    .son_ready           (son_ready)
  );

  power_relay_model power_relay_model_i (
    .ref_clk             (ref_clk),
    .rst_n               (rst_n),
    .power_req           (power_req),
    .alarm_active        (alarm_active),
    .control_power_input (control_power_input),
    .main_power_input    (main_power_input)
  );

  // =========================================================
  // Shared tasks
  always #50 ref_clk = ~ref_clk;

  // Outputs follow an input change on the third enabled edge.
  task automatic step(input int n = 5);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // =========================================================
  // Watchdog
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end

  // =========================================================
  // Main sequence
  initial begin
    logic [7:0] codes [4];
    codes = '{8'h32, 8'h50, 8'h51, 8'h10};
    ref_clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    forced_stop_input = 1'b1;
    servo_on_command = 1'b0;
    power_req = 1'b0;
    clear_req = '0;
    fault_in = '0;
    miscompares = 0;
    checked = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    step();
    check("idle outputs", {base_drive_on, dyn_brake_on, alarm_active,
          forced_stop_active, son_ready, 3'h0}, 8'h00);
    @(posedge ref_clk);
    power_req <= 1'b1;
    step();
    check("warning", 8'(main_power_warning), 8'h01);
    check("warning display", display_code, 8'hE9);
    step(20);
    check("warning gone", 8'(main_power_warning), 8'h00);
    @(posedge ref_clk);
    servo_on_command <= 1'b1;
    step(60);
    check("early servo on", {6'h00, son_ready, base_drive_on}, 8'h00);
    // A frozen clock enable must hold off the stop until it runs.
    @(posedge ref_clk);
    clk_en <= 1'b0;
    forced_stop_input <= 1'b0;
    step();
    check("frozen stop", 8'(forced_stop_active), 8'h00);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    step();
    check("stop state", 8'(forced_stop_active), 8'h01);
    check("stop brake", 8'(dyn_brake_on), 8'h01);
    check("stop drive", 8'(base_drive_on), 8'h00);
    check("stop display", display_code, 8'hE6);
    @(posedge ref_clk);
    forced_stop_input <= 1'b1;
    step();
    check("stop left", {6'h00, forced_stop_active, dyn_brake_on}, 8'h00);
    @(posedge ref_clk);
    servo_on_command <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      fault_in <= fault_in_t'(4'h8 >> i);
      step();
      check("alarm", 8'(alarm_active), 8'h01);
      check("alarm code", alarm_code, codes[i]);
      check("alarm drive", 8'(base_drive_on), 8'h00);
      check("alarm brake", 8'(dyn_brake_on), {7'h00, i != 0});
      @(posedge ref_clk);
      clear_req <= clear_req_t'({i[0], ~i[0]});
      step();
      check("clear refused", 8'(alarm_active), 8'h01);
      @(posedge ref_clk);
      clear_req <= '0;
      fault_in <= '0;
      step();
      check("alarm latched", alarm_code, codes[i]);
      @(posedge ref_clk);
      clear_req <= clear_req_t'({i[0], ~i[0]});
      step();
      check("alarm cleared", 8'(alarm_active), 8'h00);
      check("code cleared", alarm_code, 8'h00);
      @(posedge ref_clk);
      clear_req <= '0;
      step(20);
    end
    // Losing control power during a braking alarm leaves a coast.
    @(posedge ref_clk);
    fault_in <= fault_in_t'(4'h4);
    step();
    check("brake before loss", 8'(dyn_brake_on), 8'h01);
    @(posedge ref_clk);
    power_req <= 1'b0;
    step();
    check("coast on loss", 8'(dyn_brake_on), 8'h00);
    @(posedge ref_clk);
    power_req <= 1'b1;
    fault_in <= '0;
    step(20);
    @(posedge ref_clk);
    clear_req <= clear_req_t'(2'h2);
    step();
    check("final clear", 8'(alarm_active), 8'h00);
    // A reset in mid-run returns every output to idle, with no false stop.
    @(posedge ref_clk);
    rst_n <= 1'b0;
    step(2);
    check("reset outputs", {base_drive_on, dyn_brake_on, alarm_active,
          forced_stop_active, son_ready, main_power_warning, 2'h0}, 8'h00);
    check("reset display", display_code, 8'h00);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    step(1);
    check("first edge stop", 8'(forced_stop_active), 8'h00);
    check("first edge display", display_code, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
